/* File: rtl/sfp_pkg.sv */
// Operation
// - Only clock modes 0/0 and 1/1; clock idles low or high.
// - Sample inputs on rising clock edges, drive outputs from falling edges.
// - Both clock modes behave identically under extended, dual and quad protocols.
// - Only a selected device drives its outputs; deselected outputs stay released.
// - Extended is default; command on line zero, other phases as command defines.
// - Enhanced volatile write with bit 6 low, bit 7 high selects dual.
// - Volatile choice reverts at power-on, on rescue, or on another volatile write.
// - Nonvolatile bit 2 low, with bit 3 high, makes every power-on start in dual protocol.
// - Enhanced volatile write with bit 7 low selects quad protocol at once.
// - Nonvolatile bit 3 low makes every power-on start in quad protocol.
// - Quad uses four lines for everything except supply-assisted program or erase.
// - Supply-assisted program or erase in quad falls back to extended temporarily.
// - When the high-voltage supply pin drops after fallback, quad resumes.
// - A volatile configuration write takes effect at once, but one that leaves quad mid-frame waits for deselect.
// - At boot the working protocol is loaded from the nonvolatile configuration.
package sfp_pkg;

  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned LANES       = 4;
  localparam int unsigned FIFO_DEPTH  = 8;
  localparam int unsigned NV_DUAL_BIT = 2;
  localparam int unsigned NV_QUAD_BIT = 3;
  localparam int unsigned EV_DUAL_BIT = 6;
  localparam int unsigned EV_QUAD_BIT = 7;

  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_BYTE  = 4'h8;
  localparam logic [7:0] TX_IDLE   = 8'hFF;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_W1   = 4'h2;
  localparam logic [3:0] MASK_W2   = 4'h3;
  localparam logic [3:0] MASK_W4   = 4'hF;

  typedef enum logic [2:0] {
    PROTO_EXT  = 3'h1,
    PROTO_DUAL = 3'h2,
    PROTO_QUAD = 3'h4
  } sfp_proto_e;

  typedef enum logic [2:0] {
    WID_1 = 3'h1,
    WID_2 = 3'h2,
    WID_4 = 3'h4
  } sfp_width_e;

  typedef struct packed {
    logic             cs_n;
    logic             sclk;
    logic [LANES-1:0] dq;
    logic             vpp_hv;
  } sfp_pins_s;

  typedef struct packed {
    logic             dual_n;
    logic             quad_n;
  } sfp_nvcfg_s;

endpackage : sfp_pkg

/* File: rtl/sfp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap explicitly so that depths other than powers of two stay correct.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule : sfp_fifo
`default_nettype wire

/* File: rtl/sfp_spi_front.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_spi_front
  import sfp_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire sfp_pins_s         pins_i,
  input  wire sfp_nvcfg_s        nvcfg_i,
  input  wire logic              evcr_wr_i,
  input  wire logic [BYTE_W-1:0] evcr_data_i,
  input  wire logic              rescue_i,
  input  wire logic              pe_vpp_busy_i,
  input  wire sfp_width_e        ext_width_i,
  input  wire logic              drive_en_i,
  input  wire logic [BYTE_W-1:0] tx_byte_i,
  input  wire logic              tx_valid_i,
  output logic                   tx_ready_o,
  output logic      [BYTE_W-1:0] rx_byte_o,
  output logic                   rx_valid_o,
  input  wire logic              rx_ready_i,
  output logic                   rx_overrun_o,
  input  wire logic              rx_overrun_clr_i,
  output sfp_proto_e             proto_o,
  output logic                   mode3_o,
  output logic                   frame_o,
  output logic      [LANES-1:0]  dq_o,
  output logic      [LANES-1:0]  dq_oe_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Stage one feeds stage two only.

  sfp_pins_s  pins_m_reg;
  sfp_pins_s  pins_s_reg;
  logic       sclk_d_reg;
  logic       cs_act_d_reg;
  logic       vpp_d_reg;
  logic       cs_act;
  logic       rise;
  logic       fall;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pins_m_reg   <= '{cs_n: 1'b1, sclk: 1'b0, dq: '0, vpp_hv: 1'b0};
      pins_s_reg   <= '{cs_n: 1'b1, sclk: 1'b0, dq: '0, vpp_hv: 1'b0};
      sclk_d_reg   <= 1'b0;
      cs_act_d_reg <= 1'b0;
      vpp_d_reg    <= 1'b0;
    end else begin
      pins_m_reg   <= pins_i;
      pins_s_reg   <= pins_m_reg;
      sclk_d_reg   <= pins_s_reg.sclk;
      cs_act_d_reg <= cs_act;
      vpp_d_reg    <= pins_s_reg.vpp_hv;
    end
  end

  assign cs_act = ~pins_s_reg.cs_n;
  // Edges count only inside a frame, whatever the clock does outside it.
  assign rise   = cs_act && pins_s_reg.sclk && !sclk_d_reg;
  assign fall   = cs_act && !pins_s_reg.sclk && sclk_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock mode capture. The idle level at select tells mode 0 from mode 3.

  logic mode3_reg;
  logic seen_rise_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode3_reg <= 1'b0;
    end else if (cs_act && !cs_act_d_reg) begin
      mode3_reg <= pins_s_reg.sclk;
    end
  end

  // In mode 3 the first edge of a frame is falling; it must not shift data out.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      seen_rise_reg <= 1'b0;
    end else if (!cs_act) begin
      seen_rise_reg <= 1'b0;
    end else if (rise) begin
      seen_rise_reg <= 1'b1;
    end
  end

  assign mode3_o = mode3_reg;
  assign frame_o = cs_act;

  //////////////////////////////////////////////////////////////////////////////
  // Protocol selection.

  sfp_proto_e base_reg;
  sfp_proto_e proto_reg;
  sfp_proto_e proto_next;
  logic       boot_pend_reg;
  logic       fallback;

  // Boot load happens on the first clock after reset release, never under reset.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      boot_pend_reg <= 1'b1;
      base_reg      <= PROTO_EXT;
    end else if (boot_pend_reg) begin
      boot_pend_reg <= 1'b0;
      if (!nvcfg_i.quad_n) begin
        base_reg <= PROTO_QUAD;
      end else if (!nvcfg_i.dual_n) begin
        base_reg <= PROTO_DUAL;
      end else begin
        base_reg <= PROTO_EXT;
      end
    end else if (evcr_wr_i) begin
      if (!evcr_data_i[EV_QUAD_BIT]) begin
        base_reg <= PROTO_QUAD;
      end else if (!evcr_data_i[EV_DUAL_BIT]) begin
        base_reg <= PROTO_DUAL;
      end else begin
        base_reg <= PROTO_EXT;
      end
    end else if (rescue_i) begin
      base_reg <= PROTO_EXT;
    end
  end

  // Fallback tracks the supply pin level, so quad returns as soon as it drops.
  assign fallback = (base_reg == PROTO_QUAD) && pins_s_reg.vpp_hv && pe_vpp_busy_i;

  always_comb begin
    proto_next = base_reg;
    if (fallback) begin
      proto_next = PROTO_EXT;
    end
  end

  // A switch out of quad mid-frame would corrupt the byte in flight, so it waits unless fallback forces it.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      proto_reg <= PROTO_EXT;
    end else if (!cs_act || fallback || proto_reg != PROTO_QUAD) begin
      proto_reg <= proto_next;
    end
  end

  assign proto_o = proto_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Lane width of the current phase.

  sfp_width_e width;
  logic [3:0] step;
  logic [3:0] lane_mask;

  always_comb begin
    case (proto_reg)
      PROTO_DUAL: width = WID_2;
      PROTO_QUAD: width = WID_4;
      default:    width = ext_width_i;
    endcase
  end

  always_comb begin
    case (width)
      WID_2: begin
        step      = 4'h2;
        lane_mask = MASK_W2;
      end
      WID_4: begin
        step      = 4'h4;
        lane_mask = MASK_W4;
      end
      default: begin
        step      = 4'h1;
        lane_mask = MASK_W1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive shifter on rising edges.

  logic [BYTE_W-1:0] rx_sh_reg;
  logic [BYTE_W-1:0] rx_sh_next;
  logic [3:0]        rx_cnt_reg;
  logic [3:0]        rx_cnt_next;
  logic              byte_done;
  logic              push;
  logic              fifo_in_ready;

  always_comb begin
    case (width)
      WID_2:   rx_sh_next = {rx_sh_reg[5:0], pins_s_reg.dq[1:0]};
      WID_4:   rx_sh_next = {rx_sh_reg[3:0], pins_s_reg.dq[3:0]};
      default: rx_sh_next = {rx_sh_reg[6:0], pins_s_reg.dq[0]};
    endcase
  end

  assign rx_cnt_next = rx_cnt_reg + step;
  assign byte_done   = rx_cnt_next >= CNT_BYTE;
  assign push        = rise && byte_done;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sh_reg  <= '0;
      rx_cnt_reg <= CNT_ZERO;
    end else if (!cs_act) begin
      rx_cnt_reg <= CNT_ZERO;
    end else if (rise) begin
      rx_sh_reg  <= rx_sh_next;
      rx_cnt_reg <= byte_done ? CNT_ZERO : rx_cnt_next;
    end
  end

  // The link cannot be stalled, so a byte that finds the buffer full is lost
  // and flagged; the flag's set wins over a clear in the same cycle.
  logic overrun_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_reg <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      overrun_reg <= 1'b1;
    end else if (rx_overrun_clr_i) begin
      overrun_reg <= 1'b0;
    end
  end

  assign rx_overrun_o = overrun_reg;

  sfp_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_sh_next),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_byte_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transmit shifter on falling edges.

  logic [BYTE_W-1:0] tx_sh_reg;
  logic [3:0]        tx_cnt_reg;
  logic [BYTE_W-1:0] tx_src;
  logic              tx_shift;
  logic [LANES-1:0]  dq_reg;
  logic [LANES-1:0]  oe_reg;

  assign tx_shift   = fall && seen_rise_reg && drive_en_i;
  assign tx_ready_o = tx_shift && (tx_cnt_reg == CNT_ZERO);
  assign tx_src     = (tx_cnt_reg != CNT_ZERO) ? tx_sh_reg :
                      (tx_valid_i ? tx_byte_i : TX_IDLE);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_sh_reg  <= '0;
      tx_cnt_reg <= CNT_ZERO;
      dq_reg     <= '0;
    end else if (!cs_act) begin
      tx_cnt_reg <= CNT_ZERO;
    end else if (tx_shift) begin
      tx_sh_reg  <= tx_src << step;
      tx_cnt_reg <= (tx_cnt_reg == CNT_ZERO) ? CNT_BYTE - step : tx_cnt_reg - step;
      case (width)
        WID_2:   dq_reg <= {2'b00, tx_src[7:6]};
        WID_4:   dq_reg <= tx_src[7:4];
        default: dq_reg <= {2'b00, tx_src[7], 1'b0}; // Single output uses line one.
      endcase
    end
  end

  // Enables follow the synchronised select, so the bus is released within
  // three system clocks of deselect.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      oe_reg <= MASK_NONE;
    end else if (cs_act && drive_en_i) begin
      oe_reg <= lane_mask;
    end else begin
      oe_reg <= MASK_NONE;
    end
  end

  assign dq_o    = dq_reg;
  assign dq_oe_o = oe_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_fallback;
    (base_reg == PROTO_QUAD) && pins_s_reg.vpp_hv && pe_vpp_busy_i;
  endsequence

  sequence s_supply_drop;
    (base_reg == PROTO_QUAD) && vpp_d_reg && !pins_s_reg.vpp_hv && !evcr_wr_i && !rescue_i;
  endsequence

  property p_release;
    !cs_act |=> (dq_oe_o == MASK_NONE);
  endproperty
  a_release: assert property (p_release) else $error("outputs driven while deselected");

  property p_quad_sel;
    !boot_pend_reg && evcr_wr_i && !evcr_data_i[EV_QUAD_BIT] |=> (base_reg == PROTO_QUAD);
  endproperty
  a_quad_sel: assert property (p_quad_sel) else $error("quad not selected");

  property p_dual_sel;
    !boot_pend_reg && evcr_wr_i && evcr_data_i[EV_QUAD_BIT] && !evcr_data_i[EV_DUAL_BIT]
      |=> (base_reg == PROTO_DUAL);
  endproperty
  a_dual_sel: assert property (p_dual_sel) else $error("dual not selected");

  property p_revert;
    !boot_pend_reg && ((evcr_wr_i && (&evcr_data_i[EV_QUAD_BIT:EV_DUAL_BIT])) ||
      (!evcr_wr_i && rescue_i)) |=> (base_reg == PROTO_EXT);
  endproperty
  a_revert: assert property (p_revert) else $error("no return to extended");

  property p_boot_quad;
    boot_pend_reg && !nvcfg_i.quad_n |=> (base_reg == PROTO_QUAD);
  endproperty
  a_boot_quad: assert property (p_boot_quad) else $error("boot quad missed");

  property p_boot_dual;
    boot_pend_reg && nvcfg_i.quad_n && !nvcfg_i.dual_n |=> (base_reg == PROTO_DUAL);
  endproperty
  a_boot_dual: assert property (p_boot_dual) else $error("boot dual missed");

  property p_fallback;
    s_fallback |=> (proto_o == PROTO_EXT);
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback to extended");

  property p_resume;
    s_supply_drop ##0 (!cs_act) |=> (proto_o == PROTO_QUAD);
  endproperty
  a_resume: assert property (p_resume) else $error("quad not resumed");

  property p_idle_count;
    !cs_act |=> (rx_cnt_reg == CNT_ZERO) && (tx_cnt_reg == CNT_ZERO);
  endproperty
  a_idle_count: assert property (p_idle_count) else $error("counting outside frame");

  property p_drive_fall;
    (dq_o != $past(dq_o)) |-> $past(fall);
  endproperty
  a_drive_fall: assert property (p_drive_fall) else $error("output moved off a fall");

endmodule : sfp_spi_front
`default_nettype wire

/* File: sim/sfp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model
  import sfp_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic [LANES-1:0] dq_i,
  input  wire logic [LANES-1:0] dq_oe_i,
  output var  sfp_pins_s        pins_o
);
  logic             cs_n = 1'b1;
  logic             sclk = 1'b0;
  logic             vpp  = 1'b0;
  logic [LANES-1:0] h_oe = 4'h0;
  logic [LANES-1:0] h_dq = 4'h0;
  logic [LANES-1:0] flt  = 4'h0;
  logic [7:0]       rd   = 8'h00;

  // A released lane toggles every cycle, so a stale level is never read as data.
  always @(posedge clk_sys_i) begin
    flt <= ~flt;
  end

  always_comb begin
    pins_o.cs_n   = cs_n;
    pins_o.sclk   = sclk;
    pins_o.vpp_hv = vpp;
    for (int k = 0; k < LANES; k++) begin
      pins_o.dq[k] = dq_oe_i[k] ? dq_i[k] : (h_oe[k] ? h_dq[k] : flt[k]);
    end
  end

  function automatic logic [7:0] lanes(input int unsigned w);
    case (w)
      1:       lanes = {7'h00, pins_o.dq[1]};
      2:       lanes = {6'h00, pins_o.dq[1:0]};
      default: lanes = {4'h0, pins_o.dq};
    endcase
  endfunction : lanes

  ////////////////////////////////////////
  // Lanes change in the low phase and are sampled just before each rise, which
  // leaves the device a whole low phase to answer after its falling edge.
  task automatic xfer(input logic [7:0] d, input int unsigned w, input logic m3,
                      input logic rd_en);
    logic [7:0] sh;
    sh   = d;
    // Pins move on the falling system edge, never where the device samples.
    @(negedge clk_sys_i);
    sclk = m3;
    #200;
    cs_n = 1'b0;
    h_oe = rd_en ? 4'h0 : (w == 1 ? 4'h1 : (w == 2 ? 4'h3 : 4'hF));
    if (m3) begin
      #250;
      sclk = 1'b0;
    end
    for (int i = 0; i < BYTE_W / w; i++) begin
      h_dq = sh[7:4] >> (4 - w);
      sh   = sh << w;
      #250;
      rd   = (rd << w) | lanes(w);
      sclk = 1'b1;
      #150;
      if (!m3 || i < BYTE_W / w - 1) begin
        sclk = 1'b0;
      end
    end
    #250;
    rd   = (rd << w) | lanes(w);
    cs_n = 1'b1;
    h_oe = 4'h0;
    #400;
  endtask : xfer

  task automatic wiggle();
    @(negedge clk_sys_i);
    repeat (3) begin
      sclk = 1'b1;
      #200;
      sclk = 1'b0;
      #200;
    end
  endtask : wiggle
endmodule : sfp_host_model
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfp_pkg::*;

  typedef struct packed {
    logic [7:0] evcr;
    sfp_width_e ew;
    sfp_proto_e pr;
    logic [7:0] d;
  } sfp_row_s;

  logic             clk      = 1'b0;
  logic             rst      = 1'b1;
  sfp_pins_s        pins;
  sfp_nvcfg_s       nvcfg    = 2'h3;
  logic             evcr_wr  = 1'b0;
  logic [7:0]       evcr_d   = 8'h00;
  logic             rescue   = 1'b0;
  logic             pe_busy  = 1'b0;
  sfp_width_e       ext_w    = WID_1;
  logic             drive_en = 1'b0;
  logic [7:0]       tx_byte  = 8'h00;
  logic             tx_valid = 1'b0;
  logic             rx_ready = 1'b0;
  logic             ovr_clr  = 1'b0;
  logic             tx_ready;
  logic [7:0]       rx_byte;
  logic             rx_valid;
  logic             ovr;
  sfp_proto_e       proto;
  logic             mode3;
  logic             frame;
  logic [LANES-1:0] dq;
  logic [LANES-1:0] dq_oe;
  int               errors   = 0;
  int               n_tests  = 0;
  int               cycles   = 0;
  int               hi_cnt   = 0;
  int               w;
  sfp_proto_e       boot_exp [4] = '{PROTO_QUAD, PROTO_DUAL, PROTO_QUAD, PROTO_EXT};
  sfp_row_s         rows [7] = '{
    '{8'hFF, WID_1, PROTO_EXT, 8'hA5}, '{8'hFF, WID_2, PROTO_EXT, 8'h3C},
    '{8'hFF, WID_4, PROTO_EXT, 8'hC3}, '{8'hBF, WID_1, PROTO_DUAL, 8'h96},
    '{8'h7F, WID_1, PROTO_QUAD, 8'h5A}, '{8'h3F, WID_1, PROTO_QUAD, 8'h81},
    '{8'hC0, WID_1, PROTO_EXT, 8'h0F}};

  initial begin
    forever #25 clk = ~clk;
  end

  sfp_spi_front sfp_spi_front_i (
    .clk_sys_i(clk), .rst_i(rst), .pins_i(pins), .nvcfg_i(nvcfg),
    .evcr_wr_i(evcr_wr), .evcr_data_i(evcr_d), .rescue_i(rescue),
    .pe_vpp_busy_i(pe_busy), .ext_width_i(ext_w), .drive_en_i(drive_en),
    .tx_byte_i(tx_byte), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .rx_overrun_o(ovr), .rx_overrun_clr_i(ovr_clr), .proto_o(proto),
    .mode3_o(mode3), .frame_o(frame), .dq_o(dq), .dq_oe_o(dq_oe));

  sfp_host_model sfp_host_model_i (
    .clk_sys_i(clk), .dq_i(dq), .dq_oe_i(dq_oe), .pins_o(pins));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic hx(input logic [7:0] d, input int unsigned wd, input logic m3,
                    input logic rd_en);
    sfp_host_model_i.xfer(d, wd, m3, rd_en);
  endtask : hx

  task automatic pulse_evcr(input logic [7:0] v);
    @(posedge clk);
    evcr_wr <= 1'b1;
    evcr_d  <= v;
    @(posedge clk);
    evcr_wr <= 1'b0;
    tick(3);
  endtask : pulse_evcr

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    tick(11);
    check("proto_rst", proto, PROTO_EXT);
    check("oe_rst", dq_oe, MASK_NONE);
    check("rxv_rst", rx_valid, 1'b0);
    check("ovr_rst", ovr, 1'b0);
    tick(1);
    rst <= 1'b0;
    tick(4);
  endtask : do_reset

  task automatic get_rx(input logic [7:0] exp);
    int t;
    t = 0;
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (rx_valid !== 1'b1 && t < 60);
    check("rx_valid", rx_valid, 1'b1);
    check("rx_byte", rx_byte, exp);
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask : get_rx

  // The limit is several times the longest expected run, so it only trips on a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end

  always @(posedge clk) begin
    hi_cnt <= pins.cs_n ? hi_cnt + 1 : 0;
    if (hi_cnt > 5) check("oe_idle", dq_oe, MASK_NONE);
    if (tx_ready === 1'b1) tx_valid <= 1'b0;
  end

  ////////////////////////////////////////
  initial begin
    do_reset();
    check("proto_boot", proto, PROTO_EXT);
    foreach (rows[r]) begin
      ext_w <= rows[r].ew;
      pulse_evcr(rows[r].evcr);
      check("proto", proto, rows[r].pr);
      w = (rows[r].pr == PROTO_EXT) ? int'(rows[r].ew) : int'(rows[r].pr);
      for (int m = 0; m < 2; m++) begin
        hx(rows[r].d ^ 8'(m), w, m[0], 1'b0);
        get_rx(rows[r].d ^ 8'(m));
        check("mode3", mode3, 8'(m));
        check("frame", frame, 1'b0);
      end
      @(posedge clk);
      drive_en <= 1'b1;
      tx_byte  <= ~rows[r].d;
      tx_valid <= 1'b1;
      hx(8'h00, w, 1'b0, 1'b1);
      check("tx_line", sfp_host_model_i.rd, ~rows[r].d);
      check("tx_taken", tx_valid, 1'b0);
      @(posedge clk);
      drive_en <= 1'b0;
      rx_ready <= 1'b1;
      tick(10);
      rx_ready <= 1'b0;
    end
    pulse_evcr(8'h7F);
    sfp_host_model_i.vpp <= 1'b1;
    @(posedge clk);
    pe_busy <= 1'b1;
    tick(5);
    check("proto_fb", proto, PROTO_EXT);
    hx(8'h6C, 1, 1'b0, 1'b0);
    get_rx(8'h6C);
    sfp_host_model_i.vpp <= 1'b0;
    tick(6);
    check("proto_back", proto, PROTO_QUAD);
    pe_busy <= 1'b0;
    sfp_host_model_i.wiggle();
    tick(4);
    check("rx_idle", rx_valid, 1'b0);
    hx(8'hE7, 4, 1'b0, 1'b0);
    get_rx(8'hE7);
    for (int i = 0; i < 9; i++) begin
      if (i == 8) check("ovr_full", ovr, 1'b0);
      hx(8'h10 + 8'(i), 4, 1'b0, 1'b0);
    end
    tick(4);
    check("ovr", ovr, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) get_rx(8'h10 + 8'(i));
    tick(2);
    check("rx_empty", rx_valid, 1'b0);
    ovr_clr <= 1'b1;
    @(posedge clk);
    ovr_clr <= 1'b0;
    tick(2);
    check("ovr_clr", ovr, 1'b0);
    rescue <= 1'b1;
    @(posedge clk);
    rescue <= 1'b0;
    tick(3);
    check("proto_rescue", proto, PROTO_EXT);
    for (int b = 0; b < 4; b++) begin
      nvcfg <= 2'(b);
      pulse_evcr(b % 2 == 1 ? 8'h7F : 8'hBF);
      do_reset();
      check("proto_nv", proto, boot_exp[b]);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
